// >>> verilog/pep_pkg.sv
package pep_pkg;

  // Register byte offsets on the APB window
  localparam logic [11:0] PEP_OFS_CONTROL   = 12'h740;
  localparam logic [11:0] PEP_OFS_STATUS    = 12'h744;
  localparam logic [11:0] PEP_OFS_REPORT    = 12'h748;
  localparam logic [11:0] PEP_OFS_COUNTER   = 12'h74c;
  localparam logic [11:0] PEP_OFS_IRQ_MASK  = 12'h760;

  // Control register fields
  localparam int PEP_CTL_DISABLE_BIT = 0;
  localparam int PEP_CTL_INJECT_BIT  = 1;
  localparam int PEP_CTL_LEN_LSB     = 8;
  localparam int PEP_CTL_LEN_MSB     = 15;

  // Status, report and counter fields
  localparam int PEP_STS_FLAG_BIT    = 0;
  localparam int PEP_RPT_LSB         = 0;
  localparam int PEP_RPT_MSB         = 1;
  localparam int PEP_CNT_LSB         = 0;
  localparam int PEP_CNT_MSB         = 7;

  // Header byte zero sits in the top lane of the first word
  localparam int PEP_HDR_B0_LSB      = 24;
  localparam int PEP_HDR_B0_MSB      = 31;

  // Reset values
  localparam logic [7:0]  PEP_LEN_RESET  = 8'h00;
  localparam logic [7:0]  PEP_CNT_RESET  = 8'h00;
  localparam logic [7:0]  PEP_CNT_MAX    = 8'hff;
  localparam logic [31:0] PEP_RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PEP_SEV_NONE     = 2'h0,
    PEP_SEV_COR      = 2'h1,
    PEP_SEV_NONFATAL = 2'h2,
    PEP_SEV_FATAL    = 2'h3
  } pep_sev_t;

  localparam pep_sev_t PEP_RPT_RESET = PEP_SEV_NONFATAL;

  typedef enum logic [2:0] {
    PEP_REG_CONTROL = 3'h0,
    PEP_REG_STATUS  = 3'h1,
    PEP_REG_REPORT  = 3'h2,
    PEP_REG_COUNTER = 3'h3,
    PEP_REG_MASK    = 3'h4,
    PEP_REG_NONE    = 3'h7
  } pep_reg_t;

endpackage

// >>> verilog/pep_byte_parity.sv
`timescale 1ns/1ps
module pep_byte_parity import pep_pkg::*; #(
  parameter int BYTES = 4
) (
  input  wire logic [8*BYTES-1:0] data,
  output logic      [BYTES-1:0]   parity
);

  // One even parity bit per byte lane
  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : gLane
      assign parity[i] = ^data[8*i +: 8];
    end
  endgenerate

endmodule

// >>> verilog/pep_port_parity.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Function
// - Disable bit set means no parity error flagged.
// - Parity always generated toward switch core.
// - Inject bit corrupts every dword of matching packets.
// - Match field bits 15:8 versus header byte zero.
// - Error sets status bit 0, write-one clears.
// - Report only on status zero-to-one transition.
// - Severity: none, correctable, nonfatal, fatal; resets nonfatal.
// - Eight-bit error counter saturates at maximum.
// - Reading counter returns value then clears it.
module pep_port_parity import pep_pkg::*; #(
  parameter int BYTES = 4
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 porResetn,
  input  wire logic                 clkEn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 inValid,
  input  wire logic                 inSop,
  input  wire logic                 inEop,
  input  wire logic [8*BYTES-1:0]   inData,
  input  wire logic [BYTES-1:0]     inPar,
  output logic                      outValid,
  output logic                      outSop,
  output logic                      outEop,
  output logic      [8*BYTES-1:0]   outData,
  output logic      [BYTES-1:0]     outPar,
  output logic                      errMsgValid,
  output logic      [1:0]           errMsgType,
  output logic                      irq
);

  function automatic pep_reg_t regOf(input logic [11:0] a);
    unique case (a)
      PEP_OFS_CONTROL:  regOf = PEP_REG_CONTROL;
      PEP_OFS_STATUS:   regOf = PEP_REG_STATUS;
      PEP_OFS_REPORT:   regOf = PEP_REG_REPORT;
      PEP_OFS_COUNTER:  regOf = PEP_REG_COUNTER;
      PEP_OFS_IRQ_MASK: regOf = PEP_REG_MASK;
      default:          regOf = PEP_REG_NONE;
    endcase
  endfunction

  function automatic logic [BYTES-1:0] parOf(input logic [8*BYTES-1:0] d);
    logic [BYTES-1:0] p;
    p = '0;
    for (int k = 0; k < BYTES; k++) begin
      p[k] = ^d[8*k +: 8];
    end
    parOf = p;
  endfunction

  logic             ctrlDisable;
  logic             ctrlInject;
  logic [7:0]       ctrlLength;
  logic             statusFlag;
  pep_sev_t         rptSev;
  logic [7:0]       errCount;
  logic             irqMask;
  logic             matchHeld;
  logic             matchNow;
  logic             injectNow;
  logic             errDet;
  logic [BYTES-1:0] genPar;
  pep_reg_t         accReg;
  logic             setupPhase;
  logic             accessPhase;
  logic             wrAcc;
  logic             cntRead;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign accReg      = regOf(paddr);
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrAcc       = accessPhase && pwrite;
  assign cntRead     = accessPhase && !pwrite && (accReg == PEP_REG_COUNTER);
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && (accReg == PEP_REG_NONE);

  // Read data is latched in setup so the counter clear cannot disturb it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= PEP_RDATA_ZERO;
    end else if (clkEn && setupPhase) begin
      prdata <= PEP_RDATA_ZERO;
      unique case (accReg)
        PEP_REG_CONTROL: begin
          prdata[PEP_CTL_DISABLE_BIT]                 <= ctrlDisable;
          prdata[PEP_CTL_INJECT_BIT]                  <= ctrlInject;
          prdata[PEP_CTL_LEN_MSB:PEP_CTL_LEN_LSB]     <= ctrlLength;
        end
        PEP_REG_STATUS:  prdata[PEP_STS_FLAG_BIT]     <= statusFlag;
        PEP_REG_REPORT:  prdata[PEP_RPT_MSB:PEP_RPT_LSB] <= rptSev;
        PEP_REG_COUNTER: prdata[PEP_CNT_MSB:PEP_CNT_LSB] <= errCount;
        PEP_REG_MASK:    prdata[PEP_STS_FLAG_BIT]     <= irqMask;
        PEP_REG_NONE:    prdata                       <= PEP_RDATA_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky control register, kept across ordinary resets; report severity and interrupt mask reset with resetn

  always_ff @(posedge mclk or negedge porResetn) begin
    if (!porResetn) begin
      ctrlDisable <= 1'b0;
      ctrlInject  <= 1'b0;
      ctrlLength  <= PEP_LEN_RESET;
    end else if (clkEn && wrAcc && accReg == PEP_REG_CONTROL) begin
      ctrlDisable <= pwdata[PEP_CTL_DISABLE_BIT];
      ctrlInject  <= pwdata[PEP_CTL_INJECT_BIT];
      ctrlLength  <= pwdata[PEP_CTL_LEN_MSB:PEP_CTL_LEN_LSB];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rptSev  <= PEP_RPT_RESET;
      irqMask <= 1'b0;
    end else if (clkEn && wrAcc) begin
      if (accReg == PEP_REG_REPORT) begin
        rptSev <= pep_sev_t'(pwdata[PEP_RPT_MSB:PEP_RPT_LSB]);
      end
      if (accReg == PEP_REG_MASK) begin
        irqMask <= pwdata[PEP_STS_FLAG_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath: check, regenerate, inject

  pep_byte_parity #(
    .BYTES (BYTES)
  ) uParity (
    .data   (inData),
    .parity (genPar)
  );

  assign errDet    = inValid && !ctrlDisable && (genPar != inPar);
  assign matchNow  = inSop ? (inData[PEP_HDR_B0_MSB:PEP_HDR_B0_LSB] == ctrlLength)
                           : matchHeld;
  assign injectNow = ctrlInject && matchNow;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      matchHeld <= 1'b0;
    end else if (clkEn && inValid && inSop) begin
      matchHeld <= matchNow;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outSop   <= 1'b0;
      outEop   <= 1'b0;
      outData  <= '0;
      outPar   <= '0;
    end else if (clkEn) begin
      outValid <= inValid;
      outSop   <= inValid && inSop;
      outEop   <= inValid && inEop;
      if (inValid) begin
        outData <= inData;
        outPar  <= genPar ^ {BYTES{injectNow}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, reporting, counter, interrupt

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      statusFlag <= 1'b0;
    end else if (clkEn) begin
      if (errDet) begin
        statusFlag <= 1'b1;
      end else if (wrAcc && accReg == PEP_REG_STATUS && pwdata[PEP_STS_FLAG_BIT]) begin
        statusFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      errMsgValid <= 1'b0;
      errMsgType  <= PEP_SEV_NONE;
    end else if (clkEn) begin
      errMsgValid <= errDet && !statusFlag && (rptSev != PEP_SEV_NONE);
      if (errDet && !statusFlag) begin
        errMsgType <= rptSev;
      end
    end
  end

  always_ff @(posedge mclk or negedge porResetn) begin
    if (!porResetn) begin
      errCount <= PEP_CNT_RESET;
    end else if (clkEn) begin
      if (cntRead) begin
        // Keep errors landing between read capture and clear
        errCount <= errCount - prdata[PEP_CNT_MSB:PEP_CNT_LSB] + 8'(errDet);
      end else if (errDet && errCount != PEP_CNT_MAX) begin
        errCount <= errCount + 8'h01;
      end
    end
  end

  assign irq = statusFlag && irqMask;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  check_disable_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && ctrlDisable && !statusFlag) |=> (!statusFlag && !errMsgValid))
    else $error("parity error flagged while checking disabled");

  disable_count_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && ctrlDisable && !cntRead) |=> (errCount == $past(errCount)))
    else $error("error counted while checking disabled");

  parity_gen_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && inValid && !injectNow) |=> (outPar == parOf(outData)))
    else $error("outgoing parity not generated");

  inject_bad_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && inValid && ctrlInject && !inSop && matchHeld)
      |=> ((outPar ^ parOf(outData)) == {BYTES{1'b1}}))
    else $error("matching packet word not corrupted");

  match_field_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && inValid && inSop && ctrlInject
      && inData[PEP_HDR_B0_MSB:PEP_HDR_B0_LSB] != ctrlLength)
      |=> (outPar == parOf(outData)))
    else $error("header word corrupted without length match");

  status_set_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && errDet) |=> statusFlag)
    else $error("status flag not set on parity error");

  status_clear_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && !errDet && wrAcc && accReg == PEP_REG_STATUS && pwdata[PEP_STS_FLAG_BIT])
      |=> !statusFlag)
    else $error("status flag not cleared by writing one");

  status_keep_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && statusFlag && !(wrAcc && accReg == PEP_REG_STATUS)) |=> statusFlag)
    else $error("status flag dropped without a clear");

  report_edge_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && errDet && statusFlag) |=> !errMsgValid)
    else $error("error reported without status transition");

  report_once_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && errMsgValid) |=> !errMsgValid)
    else $error("error message repeated without new transition");

  report_sev_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && errDet && !statusFlag && rptSev != PEP_SEV_NONE)
      |=> (errMsgValid && errMsgType == $past(rptSev)))
    else $error("error message missing or wrong severity");

  report_none_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && rptSev == PEP_SEV_NONE) |=> !errMsgValid)
    else $error("error message sent with reporting off");

  count_sat_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && errDet && !cntRead) |=> (errCount == (($past(errCount) == PEP_CNT_MAX)
      ? PEP_CNT_MAX : $past(errCount) + 8'h01)))
    else $error("error counter did not count or saturate");

  count_hold_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && !errDet && !cntRead) |=> (errCount == $past(errCount)))
    else $error("error counter changed without an error");

  read_clear_a: assert property (@(posedge mclk) disable iff (!resetn || !porResetn)
    (clkEn && setupPhase && accReg == PEP_REG_COUNTER && !pwrite)
      ##1 (clkEn && cntRead && !errDet)
      |=> (prdata[PEP_CNT_MSB:PEP_CNT_LSB] == $past(errCount, 2)
      && errCount == $past(errCount) - prdata[PEP_CNT_MSB:PEP_CNT_LSB]))
    else $error("counter read did not return value and clear");

  inject_seen_c: cover property (@(posedge mclk) disable iff (!resetn || !porResetn)
    clkEn && inValid && injectNow && inEop);
  report_sent_c: cover property (@(posedge mclk) disable iff (!resetn || !porResetn)
    errMsgValid ##1 !errMsgValid);
  count_full_c: cover property (@(posedge mclk) disable iff (!resetn || !porResetn)
    errCount == PEP_CNT_MAX);
  set_clear_c: cover property (@(posedge mclk) disable iff (!resetn || !porResetn)
    clkEn && errDet && wrAcc && accReg == PEP_REG_STATUS);
  freeze_seen_c: cover property (@(posedge mclk) disable iff (!resetn || !porResetn)
    !clkEn && inValid);

endmodule

// >>> test/pep_core_model.sv
`timescale 1ns/1ps
module pep_core_model #(
  parameter int BYTES = 4
) (
  input  wire logic               wordValid,
  input  wire logic [8*BYTES-1:0] wordData,
  input  wire logic [BYTES-1:0]   wordPar,
  output logic                    wordBad
);
  logic [BYTES-1:0] evenPar;
  // Core side recomputes even byte parity on every word taken
  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      evenPar[i] = ^wordData[8*i+:8];
    end
  end
  assign wordBad = wordValid && (wordPar !== evenPar);
endmodule

// >>> test/pep_port_parity_tb_top.sv
`timescale 1ns/1ps
module pep_port_parity_tb_top import pep_pkg::*;;
  logic        mclk, resetn, porResetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, inData, outData;
  logic        inValid, inSop, inEop, outValid, outSop, outEop, errMsgValid, irq, wordBad;
  logic        clkEn;
  logic [3:0]  inPar, outPar;
  logic [1:0]  errMsgType;
  logic [7:0]  len;
  int          errorCnt, testsRun;
  logic [31:0] badQ[$], msgQ[$], dataQ[$], expW;
  pep_port_parity u_dut (.mclk(mclk), .resetn(resetn), .porResetn(porResetn), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .inValid(inValid), .inSop(inSop),
    .inEop(inEop), .inData(inData), .inPar(inPar), .outValid(outValid), .outSop(outSop),
    .outEop(outEop), .outData(outData), .outPar(outPar), .errMsgValid(errMsgValid),
    .errMsgType(errMsgType), .irq(irq));
  pep_core_model u_core (.wordValid(outValid), .wordData(outData), .wordPar(outPar),
    .wordBad(wordBad));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchers take the oldest note whenever a result appears
  always @(posedge mclk) begin
    if (outValid === 1'b1) begin
      expW = badQ.size() ? badQ.pop_front() : 32'hbad;
      chk({29'h0, outSop, outEop, wordBad}, expW);
      expW = dataQ.size() ? dataQ.pop_front() : 32'hbad;
      chk(outData, expW);
    end
    if (errMsgValid === 1'b1) begin
      expW = msgQ.size() ? msgQ.pop_front() : 32'hbad;
      chk({30'h0, errMsgType}, expW);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task apb(input bit isWr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rdat, output logic err);
    psel    <= 1'b1;
    pwrite  <= isWr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
  endtask
  task pkt(input int n, input logic [7:0] hdr, input bit bad, input bit expBad);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      if (i == 0) d[31:24] = hdr;
      inValid <= 1'b1;
      inSop   <= (i == 0);
      inEop   <= (i == n - 1);
      inData  <= d;
      inPar   <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ {4{bad}};
      badQ.push_back({29'h0, i == 0, i == n - 1, expBad});
      dataQ.push_back(d);
      @(posedge mclk);
    end
    inValid <= 1'b0;
    inSop   <= 1'b0;
    inEop   <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic        e;
    {resetn, porResetn, psel, penable, pwrite, inValid, inSop, inEop} = '0;
    clkEn = 1'b1;
    {paddr, pwdata, inData, inPar} = '0;
    void'($urandom(46));
    repeat (16) @(posedge mclk);
    resetn    <= 1'b1;
    porResetn <= 1'b1;
    @(posedge mclk);
    rd(PEP_OFS_CONTROL, 32'h0);
    rd(PEP_OFS_STATUS, 32'h0);
    rd(PEP_OFS_REPORT, 32'h2);
    rd(PEP_OFS_COUNTER, 32'h0);
    apb(1'b0, 12'h750, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    wr(PEP_OFS_IRQ_MASK, 32'h1);
    pkt(2, 8'h11, 1'b0, 1'b0);
    msgQ.push_back(32'h2);
    pkt(1, 8'h11, 1'b1, 1'b0);
    chk({31'h0, irq}, 32'h1);
    rd(PEP_OFS_STATUS, 32'h1);
    pkt(2, 8'h11, 1'b1, 1'b0);
    rd(PEP_OFS_COUNTER, 32'h3);
    rd(PEP_OFS_COUNTER, 32'h0);
    wr(PEP_OFS_STATUS, 32'h1);
    rd(PEP_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    clkEn   <= 1'b0;
    inValid <= 1'b1;
    inSop   <= 1'b1;
    inEop   <= 1'b1;
    inData  <= 32'h0;
    inPar   <= 4'hf;
    repeat (3) @(posedge mclk);
    clkEn   <= 1'b1;
    {inValid, inSop, inEop} <= 3'h0;
    @(posedge mclk);
    rd(PEP_OFS_STATUS, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(PEP_OFS_REPORT, s);
      if (s != 0) msgQ.push_back(s);
      pkt(1, 8'h22, 1'b1, 1'b0);
      wr(PEP_OFS_STATUS, 32'h1);
    end
    rd(PEP_OFS_COUNTER, 32'h4);
    wr(PEP_OFS_CONTROL, 32'h1);
    pkt(2, 8'h33, 1'b1, 1'b0);
    rd(PEP_OFS_STATUS, 32'h0);
    rd(PEP_OFS_COUNTER, 32'h0);
    len = 8'($urandom);
    wr(PEP_OFS_CONTROL, {16'h0, len, 8'h02});
    pkt(3, len, 1'b0, 1'b1);
    pkt(3, len ^ 8'h80, 1'b0, 1'b0);
    wr(PEP_OFS_CONTROL, 32'h0);
    msgQ.push_back(32'h3);
    pkt(260, 8'h44, 1'b1, 1'b0);
    rd(PEP_OFS_COUNTER, 32'hff);
    pkt(3, 8'h44, 1'b1, 1'b0);
    wr(PEP_OFS_CONTROL, 32'h0000_ab01);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(PEP_OFS_CONTROL, 32'h0000_ab01);
    rd(PEP_OFS_COUNTER, 32'h3);
    rd(PEP_OFS_REPORT, 32'h2);
    rd(PEP_OFS_STATUS, 32'h0);
    porResetn <= 1'b0;
    repeat (2) @(posedge mclk);
    porResetn <= 1'b1;
    @(posedge mclk);
    rd(PEP_OFS_CONTROL, 32'h0);
    chk(badQ.size() + msgQ.size() + dataQ.size(), 32'h0);
    report_and_stop;
  end
  initial begin
    #(25 * 20000);
    errorCnt++;
    report_and_stop;
  end
endmodule
